// >>> aot_cfg.svh
/*
 * Constants for the auxiliary offset trim and ECC readout register bank.
 * Assumes it is included by its bare name wherever a constant is needed.
 */
`ifndef AOT_CFG_SVH
`define AOT_CFG_SVH

// Register indices; the byte address on the bus is four times the index.
`define AOT_IDX_AUX2_TRIM   10'h0d8
`define AOT_IDX_AUX3_TRIM   10'h0da
`define AOT_IDX_AUX4_TRIM   10'h0dc
`define AOT_IDX_AUX5_TRIM   10'h0de
`define AOT_IDX_AUX6_TRIM   10'h0e0
`define AOT_IDX_AUX7_TRIM   10'h0e2
`define AOT_IDX_ECC_STATUS  10'h0e4
`define AOT_IDX_ECC_HI      10'h0e6
`define AOT_IDX_ECC_LO      10'h0e7

`define AOT_ADDR_W          12
`define AOT_IDX_LSB         2
`define AOT_NUM_TRIM        6
`define AOT_TRIM_W          10
`define AOT_TRIM_MSB        9
`define AOT_TRIM_LANE0_MSB  7
`define AOT_TRIM_RST        10'h000
`define AOT_FIRST_TRIM_CHAN 3'h2

`define AOT_CODE_W          16
`define AOT_CODE_MIN        16'h0000
`define AOT_CODE_MAX        16'hffff
`define AOT_SUM_W           18

`define AOT_ECC_USER_CORR   64'h18c3ff8a68a98069
`define AOT_ECC_FACT_CORR   64'hcc72d18280ba9767
`define AOT_ECC_UNCORR      64'h0000000000000000
`define AOT_ECC_RST         64'h0000000000000000

`endif

// >>> aot_pkg.sv
/*
 * Types shared by the auxiliary offset trim and ECC readout bank.
 * Assumes aot_cfg.svh supplies the widths.
 */
`include "aot_cfg.svh"

package aot_pkg;

  typedef struct packed {
    logic [2:0]               chan;
    logic [`AOT_CODE_W-1:0]   code;
  } aot_sample_t;

  typedef struct packed {
    logic factory;
    logic correctable;
  } aot_ecc_report_t;

  typedef enum logic [1:0] {
    AOT_ECC_NONE,
    AOT_ECC_USER_CORR,
    AOT_ECC_FACT_CORR,
    AOT_ECC_NOT_CORR
  } aot_ecc_kind_t;

endpackage

// >>> aot_offset_trim_bank.sv
/*
 * Offset trim registers for auxiliary channels 2 to 7, the saturating
 * correction datapath that applies them, and the read-only 64-bit ECC
 * self-test result, all reached by software over an APB slave.
 * Assumes one 40 MHz clock, a synchronous active-low reset, ADC results and
 * ECC test reports that arrive from logic on the same clock, and an APB
 * master that keeps the bus protocol.
 */
`timescale 1ns/10ps
`include "aot_cfg.svh"

module aot_offset_trim_bank (
  input  wire logic                         clock_in,
  input  wire logic                         reset_n_in,
  input  wire logic                         psel_in,
  input  wire logic                         penable_in,
  input  wire logic                         pwrite_in,
  input  wire logic [`AOT_ADDR_W-1:0]       paddr_in,
  input  wire logic [31:0]                  pwdata_in,
  input  wire logic [3:0]                   pstrb_in,
  output logic      [31:0]                  prdata_out,
  output logic                              pready_out,
  output logic                              pslverr_out,
  input  wire logic                         sample_valid_in,
  input  wire aot_pkg::aot_sample_t         sample_in,
  input  wire logic                         ecc_done_in,
  input  wire aot_pkg::aot_ecc_report_t     ecc_report_in,
  output logic                              corr_valid_out,
  output aot_pkg::aot_sample_t              corr_sample_out,
  output logic                              corr_clipped_out
);

  logic [`AOT_TRIM_W-1:0]    trim_reg [`AOT_NUM_TRIM];
  logic [63:0]               ecc_result_reg;
  aot_pkg::aot_ecc_kind_t    ecc_kind_reg;
  logic                      ecc_seen_reg;

  logic [31:0]               prdata_reg;
  logic [31:0]               prdata_next;
  logic                      pready_reg;
  logic                      pslverr_reg;
  logic                      pslverr_next;

  logic                      corr_valid_reg;
  aot_pkg::aot_sample_t      corr_sample_reg;
  logic                      corr_clipped_reg;

  logic [9:0]                bus_index;
  logic                      setup_phase;
  logic                      write_commit;
  logic                      hit_trim;
  logic [2:0]                hit_trim_slot;
  logic                      hit_ecc;
  logic                      hit_mapped;

  // Index of every trim register, in channel order.
  logic [9:0]                trim_index [`AOT_NUM_TRIM];

  assign trim_index[0] = `AOT_IDX_AUX2_TRIM;
  assign trim_index[1] = `AOT_IDX_AUX3_TRIM;
  assign trim_index[2] = `AOT_IDX_AUX4_TRIM;
  assign trim_index[3] = `AOT_IDX_AUX5_TRIM;
  assign trim_index[4] = `AOT_IDX_AUX6_TRIM;
  assign trim_index[5] = `AOT_IDX_AUX7_TRIM;

  // Address decode.

  assign bus_index   = paddr_in[`AOT_ADDR_W-1:`AOT_IDX_LSB];
  assign setup_phase = psel_in && !penable_in;

  // A write lands only on the access edge at which pready is seen high.
  assign write_commit = psel_in && penable_in && pready_reg && pwrite_in && !pslverr_reg;

  always_comb begin
    hit_trim      = 1'b0;
    hit_trim_slot = 3'h0;
    for (int i = 0; i < `AOT_NUM_TRIM; i++) begin
      if (bus_index == trim_index[i]) begin
        hit_trim      = 1'b1;
        hit_trim_slot = 3'(i);
      end
    end
  end

  assign hit_ecc = (bus_index == `AOT_IDX_ECC_HI) ||
                   (bus_index == `AOT_IDX_ECC_LO) ||
                   (bus_index == `AOT_IDX_ECC_STATUS);

  assign hit_mapped = hit_trim || hit_ecc;

  // Read data and error answer, prepared in the setup cycle.

  always_comb begin
    prdata_next  = 32'h0000_0000;
    pslverr_next = 1'b0;
    if (!hit_mapped) begin
      pslverr_next = 1'b1;
    end else if (hit_ecc && pwrite_in) begin
      // The ECC words are read-only; a write is refused with an error.
      pslverr_next = 1'b1;
    end else if (hit_trim) begin
      prdata_next[`AOT_TRIM_MSB:0] = trim_reg[hit_trim_slot];
    end else if (bus_index == `AOT_IDX_ECC_HI) begin
      prdata_next = ecc_result_reg[63:32];
    end else if (bus_index == `AOT_IDX_ECC_LO) begin
      prdata_next = ecc_result_reg[31:0];
    end else begin
      prdata_next[0]   = ecc_seen_reg;
      prdata_next[2:1] = ecc_kind_reg;
    end
  end

  // Bus answer: one access cycle with no wait state.

  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      pready_reg <= 1'b0;
    end else begin
      pready_reg <= setup_phase;
    end
  end

  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      prdata_reg  <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end else if (setup_phase) begin
      prdata_reg  <= pwrite_in ? 32'h0000_0000 : prdata_next;
      pslverr_reg <= pslverr_next;
    end else if (!psel_in) begin
      prdata_reg  <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end
  end

  assign prdata_out  = prdata_reg;
  assign pready_out  = pready_reg;
  assign pslverr_out = pslverr_reg;

  // Trim registers. Only the ten value bits are stored, so the reserved
  // bits cannot hold anything and always read back as zero.

  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      for (int i = 0; i < `AOT_NUM_TRIM; i++) begin
        trim_reg[i] <= `AOT_TRIM_RST;
      end
    end else if (write_commit && hit_trim) begin
      if (pstrb_in[0]) begin
        trim_reg[hit_trim_slot][`AOT_TRIM_LANE0_MSB:0] <= pwdata_in[`AOT_TRIM_LANE0_MSB:0];
      end
      if (pstrb_in[1]) begin
        trim_reg[hit_trim_slot][`AOT_TRIM_MSB:`AOT_TRIM_LANE0_MSB+1] <=
          pwdata_in[`AOT_TRIM_MSB:`AOT_TRIM_LANE0_MSB+1];
      end
    end
  end

  // ECC self-test result capture.

  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      ecc_result_reg <= `AOT_ECC_RST;
      ecc_kind_reg   <= aot_pkg::AOT_ECC_NONE;
      ecc_seen_reg   <= 1'b0;
    end else if (ecc_done_in) begin
      ecc_seen_reg <= 1'b1;
      if (!ecc_report_in.correctable) begin
        ecc_result_reg <= `AOT_ECC_UNCORR;
        ecc_kind_reg   <= aot_pkg::AOT_ECC_NOT_CORR;
      end else if (ecc_report_in.factory) begin
        ecc_result_reg <= `AOT_ECC_FACT_CORR;
        ecc_kind_reg   <= aot_pkg::AOT_ECC_FACT_CORR;
      end else begin
        ecc_result_reg <= `AOT_ECC_USER_CORR;
        ecc_kind_reg   <= aot_pkg::AOT_ECC_USER_CORR;
      end
    end
  end

  // Correction datapath.

  logic                      chan_trimmed;
  logic [2:0]                trim_slot;
  logic [`AOT_TRIM_W-1:0]    trim_sel;
  logic [`AOT_SUM_W-1:0]     code_ext;
  logic [`AOT_SUM_W-1:0]     trim_ext;
  logic [`AOT_SUM_W-1:0]     sum;
  logic [`AOT_CODE_W-1:0]    code_next;
  logic                      clipped_next;

  assign chan_trimmed = (sample_in.chan >= `AOT_FIRST_TRIM_CHAN);
  assign trim_slot    = sample_in.chan - `AOT_FIRST_TRIM_CHAN;

  // Channels 0 and 1 are corrected elsewhere and pass through untouched.
  assign trim_sel = chan_trimmed ? trim_reg[trim_slot] : `AOT_TRIM_RST;

  // The trim is added at the result's own LSB weight, with no shift.
  assign code_ext = {{(`AOT_SUM_W-`AOT_CODE_W){1'b0}}, sample_in.code};
  assign trim_ext = {{(`AOT_SUM_W-`AOT_TRIM_W){trim_sel[`AOT_TRIM_MSB]}}, trim_sel};
  assign sum      = code_ext + trim_ext;

  // Two spare sum bits let the sign and the carry be told apart, so the
  // clamp never mistakes a large positive sum for a negative one.
  always_comb begin
    code_next    = sum[`AOT_CODE_W-1:0];
    clipped_next = 1'b0;
    if (sum[`AOT_SUM_W-1]) begin
      code_next    = `AOT_CODE_MIN;
      clipped_next = 1'b1;
    end else if (sum[`AOT_CODE_W]) begin
      code_next    = `AOT_CODE_MAX;
      clipped_next = 1'b1;
    end
  end

  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      corr_valid_reg <= 1'b0;
    end else begin
      corr_valid_reg <= sample_valid_in;
    end
  end

  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      corr_sample_reg  <= '0;
      corr_clipped_reg <= 1'b0;
    end else if (sample_valid_in) begin
      corr_sample_reg.chan <= sample_in.chan;
      corr_sample_reg.code <= code_next;
      corr_clipped_reg     <= clipped_next;
    end
  end

  assign corr_valid_out   = corr_valid_reg;
  assign corr_sample_out  = corr_sample_reg;
  assign corr_clipped_out = corr_clipped_reg;

endmodule

// >>> aot_offset_trim_bank_asserts.sv
/* Checker for the trim and ECC readout bank.
   Bound to every aot_offset_trim_bank instance; sees only its ports. */
`timescale 1ns/10ps
`include "aot_cfg.svh"
module aot_offset_trim_bank_asserts (
  input wire logic                     clock_in,
  input wire logic                     reset_n_in,
  input wire logic                     psel_in,
  input wire logic                     penable_in,
  input wire logic                     pwrite_in,
  input wire logic [11:0]              paddr_in,
  input wire logic [31:0]              prdata_out,
  input wire logic                     pready_out,
  input wire logic                     sample_valid_in,
  input wire aot_pkg::aot_sample_t     sample_in,
  input wire logic                     ecc_done_in,
  input wire aot_pkg::aot_ecc_report_t ecc_report_in,
  input wire logic                     corr_valid_out,
  input wire aot_pkg::aot_sample_t     corr_sample_out,
  input wire logic                     corr_clipped_out
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!reset_n_in);
  logic [1:0] kind_reg;
  logic       rd_acc;
  // Kind of the last finished test: 1 user, 2 factory, 3 not correctable.
  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      kind_reg <= 2'h0;
    end else if (ecc_done_in) begin
      kind_reg <= ecc_report_in.correctable ? (ecc_report_in.factory ? 2'h2 : 2'h1) : 2'h3;
    end
  end
  assign rd_acc = pready_out && psel_in && penable_in && !pwrite_in;
  AST_NO_WAIT: assert property (psel_in && !penable_in |=> pready_out) else $error("no answer in access");
  AST_CORR_NEXT: assert property (sample_valid_in |=> corr_valid_out) else $error("late result");
  AST_CORR_QUIET: assert property (!sample_valid_in |=> !corr_valid_out) else $error("stray result");
  AST_CHAN_KEPT: assert property (sample_valid_in |=> corr_sample_out.chan == $past(sample_in.chan))
    else $error("channel lost");
  AST_CLIP_EDGE: assert property (corr_valid_out && corr_clipped_out |-> corr_sample_out.code inside {16'h0000, 16'hffff})
    else $error("clip not at rail");
  AST_RSVD_READ: assert property (rd_acc && paddr_in[11:2] inside {[`AOT_IDX_AUX2_TRIM:`AOT_IDX_AUX7_TRIM]}
    |-> prdata_out[31:10] == 22'h0) else $error("reserved bits set");
  AST_ECC_USER: assert property (rd_acc && paddr_in[11:2] == `AOT_IDX_ECC_HI && kind_reg == 2'h1
    |-> prdata_out == 32'h18c3ff8a) else $error("user result wrong");
  AST_ECC_FACT: assert property (rd_acc && paddr_in[11:2] == `AOT_IDX_ECC_LO && kind_reg == 2'h2
    |-> prdata_out == 32'h80ba9767) else $error("factory result wrong");
  AST_ECC_ZERO: assert property (rd_acc && paddr_in[11:3] == 9'h073 && kind_reg == 2'h3
    |-> prdata_out == 32'h0) else $error("uncorrectable not zero");
endmodule
bind aot_offset_trim_bank aot_offset_trim_bank_asserts i_asserts (.clock_in(clock_in), .reset_n_in(reset_n_in),
  .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in), .prdata_out(prdata_out),
  .pready_out(pready_out), .sample_valid_in(sample_valid_in), .sample_in(sample_in), .ecc_done_in(ecc_done_in),
  .ecc_report_in(ecc_report_in), .corr_valid_out(corr_valid_out), .corr_sample_out(corr_sample_out),
  .corr_clipped_out(corr_clipped_out));

// >>> aot_offset_trim_bank_tb.sv
/* Self-checking bench for the trim and ECC readout bank.
   Assumes the design answers APB with fewer than 20 wait states and a result one cycle after each sample. */
`timescale 1ns/10ps
`include "aot_cfg.svh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin mismatches++; $display("BAD %0t %h vs %h", $time, g, e); end end
module aot_offset_trim_bank_tb;
  logic                     clk, rst_n, psel, pen, pwr, sv, done, prdy, perr, cv, cclip;
  logic [11:0]              paddr;
  logic [31:0]              pwd, prd, rd, hi;
  logic [3:0]               pstrb;
  logic                     er;
  aot_pkg::aot_sample_t     smp, cs;
  aot_pkg::aot_ecc_report_t rep;
  int                       mismatches, compares;
  aot_offset_trim_bank i_aot_offset_trim_bank (.clock_in(clk), .reset_n_in(rst_n), .psel_in(psel), .penable_in(pen),
    .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwd), .pstrb_in(pstrb), .prdata_out(prd), .pready_out(prdy),
    .pslverr_out(perr), .sample_valid_in(sv), .sample_in(smp), .ecc_done_in(done), .ecc_report_in(rep),
    .corr_valid_out(cv), .corr_sample_out(cs), .corr_clipped_out(cclip));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic end_sim;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // Data are taken in the access cycle and the request drops at the edge that sees pready.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    @(posedge clk) begin psel <= 1'b1; pen <= 1'b0; pwr <= w; paddr <= a; pwd <= d; pstrb <= s; end
    @(posedge clk) pen <= 1'b1;
    n = 0;
    // The answer is read at the very edge that samples pready high, then the request drops.
    @(posedge clk);
    while (prdy !== 1'b1 && n < 20) begin @(posedge clk); n++; end
    rd = prd;
    er = perr;
    psel <= 1'b0;
    pen  <= 1'b0;
    if (n >= 20) begin mismatches++; end_sim(); end
  endtask
  task automatic sample(input logic [2:0] ch, input logic [15:0] code, input logic [9:0] tr);
    int e;
    logic c;
    e = int'(code) + int'($signed(tr));
    c = (e < 0) || (e > 65535);
    e = (e < 0) ? 0 : ((e > 65535) ? 65535 : e);
    @(posedge clk) begin sv <= 1'b1; smp <= {ch, code}; end
    @(posedge clk) sv <= 1'b0;
    #1;
    `CHK(cv, 1'b1)
    `CHK(cs.code, e[15:0])
    `CHK(cs.chan, ch)
    `CHK(cclip, c)
  endtask
  task automatic test_regs;
    for (int k = 0; k < 6; k++) begin
      apb(1'b0, 12'(12'h360 + 8 * k), 32'h0, 4'h0);
      `CHK(rd, 32'h0)
      apb(1'b1, 12'(12'h360 + 8 * k), 32'h000003ff, 4'hf);
      apb(1'b0, 12'(12'h360 + 8 * k), 32'h0, 4'h0);
      `CHK(rd, 32'h3ff)
      apb(1'b1, 12'(12'h360 + 8 * k), 32'h0, 4'h2);
      apb(1'b0, 12'(12'h360 + 8 * k), 32'h0, 4'h0);
      `CHK(rd, 32'h0ff)
    end
    apb(1'b1, 12'h398, 32'h12345678, 4'hf);
    `CHK(er, 1'b1)
    apb(1'b0, 12'h398, 32'h0, 4'h0);
    `CHK(rd, 32'h0)
    apb(1'b0, 12'h3a0, 32'h0, 4'h0);
    `CHK(er, 1'b1)
    $display("test regs done");
  endtask
  task automatic test_corr;
    logic [9:0]  tt[6] = '{10'h3ff, 10'h200, 10'h1ff, 10'h1ff, 10'h200, 10'h001};
    logic [15:0] cc[6] = '{16'h1000, 16'h0100, 16'hff00, 16'h1000, 16'h1000, 16'hfffe};
    for (int k = 0; k < 6; k++) begin
      apb(1'b1, 12'(12'h360 + 8 * k), {22'h0, tt[k]}, 4'hf);
      sample(3'(2 + k), cc[k], tt[k]);
    end
    sample(3'h0, 16'h1234, 10'h000);
    $display("test corr done");
  endtask
  task automatic test_ecc;
    logic [63:0] ex[4] = '{64'h0, 64'h18c3ff8a68a98069, 64'h0, 64'hcc72d18280ba9767};
    logic [31:0] st[4] = '{32'h7, 32'h3, 32'h7, 32'h5};
    for (int k = 0; k < 4; k++) begin
      @(posedge clk) begin done <= 1'b1; rep <= 2'(k); end
      @(posedge clk) done <= 1'b0;
      apb(1'b0, 12'h398, 32'h0, 4'h0);
      hi = rd;
      apb(1'b0, 12'h39c, 32'h0, 4'h0);
      `CHK({hi, rd}, ex[k])
      apb(1'b0, 12'h390, 32'h0, 4'h0);
      `CHK(rd, st[k])
    end
    $display("test ecc done");
  endtask
  initial begin
    {rst_n, psel, pen, pwr, sv, done, paddr, pwd, pstrb, smp, rep} = '0;
    mismatches = 0;
    compares = 0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    test_regs();
    test_corr();
    test_ecc();
    end_sim();
  end
endmodule
